// >>> cmt_pkg.sv
// shared constants for the capture/match timer: register map, fields, codes
// assumes a single 10 MHz bus clock and a simple strobe register port
package cmt_pkg;

	// ==========================================================
	// sizes
	localparam int CMT_NMAT = 4;
	localparam int CMT_NCAP = 3;
	localparam int CMT_AW = 8;
	localparam int CMT_DW = 32;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] OFS_COUNT_CTRL = 8'h04;
	localparam logic [7:0] OFS_COUNT_VALUE = 8'h08;
	localparam logic [7:0] OFS_PRESCALE_LIMIT = 8'h0c;
	localparam logic [7:0] OFS_PRESCALE_COUNT = 8'h10;
	localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
	localparam logic [7:0] OFS_MATCH_REG0 = 8'h18;
	localparam logic [7:0] OFS_CAPTURE_CTRL = 8'h28;
	localparam logic [7:0] OFS_CAPTURE_REG0 = 8'h2c;
	localparam logic [7:0] OFS_EXT_MATCH_CTRL = 8'h3c;
	localparam logic [7:0] OFS_COUNT_MODE = 8'h70;
	localparam logic [7:0] OFS_PWM_CTRL = 8'h74;
	localparam logic [7:0] OFS_MATCH_SHADOW0 = 8'h78;
	localparam logic [7:0] OFS_STEP = 8'h04;

	// ==========================================================
	// field positions
	localparam int CTL_ENABLE = 0;
	localparam int CTL_RESET = 1;
	localparam int IRQ_CAP_BASE = 4;
	localparam int IRQ_W = 7;
	localparam int MCR_STRIDE = 3;
	localparam int MCR_INT = 0;
	localparam int MCR_RST = 1;
	localparam int MCR_STOP = 2;
	localparam int MCR_RELOAD_BASE = 24;
	localparam int MCR_W = 28;
	localparam int CCR_STRIDE = 3;
	localparam int CCR_INT = 2;
	localparam int CCR_W = 9;
	localparam int EMR_ACT_BASE = 4;
	localparam int EMR_W = 12;
	localparam int MODE_SEL_LO = 2;
	localparam int MODE_CLR_EN = 4;
	localparam int MODE_CLR_CH_LO = 5;
	localparam int MODE_CLR_FALL = 7;
	localparam int MODE_W = 8;

	// ==========================================================
	// codes
	typedef enum logic [1:0] {
		CMT_CNT_TIMER = 2'b00,
		CMT_CNT_RISE = 2'b01,
		CMT_CNT_FALL = 2'b10,
		CMT_CNT_BOTH = 2'b11
	} cmt_cnt_mode_e;

	typedef enum logic [1:0] {
		CMT_ACT_NONE = 2'b00,
		CMT_ACT_LOW = 2'b01,
		CMT_ACT_HIGH = 2'b10,
		CMT_ACT_TOGGLE = 2'b11
	} cmt_act_e;

	// bit 0 selects rising, bit 1 falling; shared by count and capture
	function automatic logic cmt_edge_pick(input logic rise, input logic fall,
		input logic [1:0] sel);
		return (sel[0] & rise) | (sel[1] & fall);
	endfunction : cmt_edge_pick

endpackage : cmt_pkg

// >>> cmt_cap_sync.sv
// synchroniser and edge detector for the capture input pins
// assumes asynchronous pins; edges appear two clocks after the pin moves
module cmt_cap_sync import cmt_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// pins
	input wire logic [CMT_NCAP-1:0] pin_in,
	// edge pulses
	output logic [CMT_NCAP-1:0] rise,
	output logic [CMT_NCAP-1:0] fall
);

	typedef struct packed {
		logic [CMT_NCAP-1:0] meta;
		logic [CMT_NCAP-1:0] sync;
		logic [CMT_NCAP-1:0] last;
	} cmt_sync_s;

	cmt_sync_s sync_reg;
	cmt_sync_s sync_next;

	// ==========================================================
	// first stage is read only by the second stage
	always_comb begin
		sync_next = sync_reg;
		sync_next.meta = pin_in;
		sync_next.sync = sync_reg.meta;
		sync_next.last = sync_reg.sync;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign rise = sync_reg.sync & ~sync_reg.last;
	assign fall = ~sync_reg.sync & sync_reg.last;

endmodule : cmt_cap_sync

// >>> cmt_match_out.sv
// next state of the four match outputs, from match events and settings
// pure logic; the caller holds the output flip-flops
module cmt_match_out import cmt_pkg::*; (
	// events
	input wire logic [CMT_NMAT-1:0] match_evt,
	input wire logic restart,
	// settings
	input wire logic [2*CMT_NMAT-1:0] act,
	input wire logic [CMT_NMAT-1:0] pwm_en,
	// state
	input wire logic [CMT_NMAT-1:0] cur,
	output logic [CMT_NMAT-1:0] nxt
);

	// ==========================================================
	// pwm: low from cycle restart, high from its own match on
	for (genvar i = 0; i < CMT_NMAT; i++) begin : g_ch
		always_comb begin
			nxt[i] = cur[i];
			if (pwm_en[i]) begin
				if (match_evt[i]) begin
					nxt[i] = 1'b1;
				end else if (restart) begin
					nxt[i] = 1'b0;
				end
			end else if (match_evt[i]) begin
				case (cmt_act_e'(act[2*i +: 2]))
					CMT_ACT_LOW: nxt[i] = 1'b0;
					CMT_ACT_HIGH: nxt[i] = 1'b1;
					CMT_ACT_TOGGLE: nxt[i] = ~cur[i];
					default: nxt[i] = cur[i];
				endcase
			end
		end
	end

endmodule : cmt_match_out

// >>> cmt_timer.sv
// 32-bit capture/match timer with prescaler, register port and match pins
// assumes capture pins are asynchronous and the bus master never overlaps
// read and write strobes
//
// What this block does
// - 32-bit counter advances only when prescaler reaches its limit.
// - timer mode counts bus clocks, counter mode counts external edges.
// - three capture registers snapshot the count on input edges.
// - a chosen capture edge clears count and prescaler.
// - four match registers compare on each count advance, optional flag on match.
// - match may stop count and prescaler.
// - match may reset the count to zero.
// - match registers reload from shadows on counter reset or reset on match, not on capture clear or wrap.
// - match outputs toggle, go low, go high or stay on match.
// - match outputs governed by external match and pwm controls.
// - pwm: one match sets period, others give single-edge waveforms.
// - each capture pin feeds exactly one capture channel.
// - a capture signal can be the counting clock.
// - match events act internally regardless of pin routing.
// - count advances every prescale limit plus one enabled cycles.
// - counter reset bit clears and holds count and prescaler.
// - count wraps from all ones to zero without a flag.
// - flags clear by writing one; writing zero does nothing.
module cmt_timer import cmt_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [CMT_AW-1:0] reg_addr,
	input wire logic [CMT_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CMT_DW-1:0] reg_rdata,
	// pins
	input wire logic [CMT_NCAP-1:0] capture_input_pin,
	output logic [CMT_NMAT-1:0] match_output_pin
);

	typedef struct packed {
		logic [IRQ_W-1:0] interrupt_flags;
		logic cen;
		logic crst;
		logic [31:0] count_value;
		logic [31:0] prescale_limit;
		logic [31:0] prescale_count;
		logic [MCR_W-1:0] match_control;
		logic [CMT_NMAT-1:0][31:0] match_registers;
		logic [CCR_W-1:0] capture_control;
		logic [CMT_NCAP-1:0][31:0] capture_value;
		logic [2*CMT_NMAT-1:0] match_action;
		logic [CMT_NMAT-1:0] match_state;
		logic [MODE_W-1:0] count_mode;
		logic [CMT_NMAT-1:0] pwm_control;
		logic [CMT_NMAT-1:0][31:0] match_shadow;
		logic [31:0] rdata;
	} cmt_state_s;

	cmt_state_s st_reg;
	cmt_state_s st_next;

	logic [CMT_NCAP-1:0] cap_rise;
	logic [CMT_NCAP-1:0] cap_fall;
	logic [CMT_NMAT-1:0] match_evt;
	logic [CMT_NMAT-1:0] mat_next;
	logic [CMT_NCAP-1:0] cap_evt;
	logic [CMT_NMAT-1:0] irq_m;
	logic [CMT_NCAP-1:0] irq_c;
	logic src_pulse;
	logic adv;
	logic pre_hit;
	logic tick;
	logic m_reset;
	logic m_stop;
	logic cap_clear;
	logic restart;

	// ==========================================================
	// pin conditioning and match outputs
	cmt_cap_sync u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(capture_input_pin),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	cmt_match_out u_mout (
		.match_evt(match_evt),
		.restart(restart),
		.act(st_reg.match_action),
		.pwm_en(st_reg.pwm_control),
		.cur(st_reg.match_state),
		.nxt(mat_next)
	);

	// ==========================================================
	// events
	always_comb begin
		logic [1:0] mode;
		logic [1:0] sel;
		logic [1:0] csel;
		mode = st_reg.count_mode[1:0];
		sel = st_reg.count_mode[MODE_SEL_LO +: 2];
		csel = st_reg.count_mode[MODE_CLR_CH_LO +: 2];
		// an out-of-range input select simply never counts
		if (cmt_cnt_mode_e'(mode) == CMT_CNT_TIMER) begin
			src_pulse = 1'b1;
		end else if (sel < 2'(CMT_NCAP)) begin
			src_pulse = cmt_edge_pick(cap_rise[sel], cap_fall[sel], mode);
		end else begin
			src_pulse = 1'b0;
		end
		cap_clear = 1'b0;
		if (st_reg.count_mode[MODE_CLR_EN] && csel < 2'(CMT_NCAP)) begin
			cap_clear = st_reg.count_mode[MODE_CLR_FALL] ? cap_fall[csel]
				: cap_rise[csel];
		end
	end

	assign adv = st_reg.cen && !st_reg.crst && src_pulse;
	assign pre_hit = st_reg.prescale_count == st_reg.prescale_limit;
	assign tick = adv && pre_hit;

	// match events exist with or without a pin routed to the output
	for (genvar i = 0; i < CMT_NMAT; i++) begin : g_match
		assign match_evt[i] = tick
			&& st_reg.count_value == st_reg.match_registers[i];
		assign irq_m[i] = match_evt[i]
			&& st_reg.match_control[MCR_STRIDE*i + MCR_INT];
	end

	for (genvar i = 0; i < CMT_NCAP; i++) begin : g_cap
		assign cap_evt[i] = cmt_edge_pick(cap_rise[i], cap_fall[i],
			st_reg.capture_control[CCR_STRIDE*i +: 2]);
		assign irq_c[i] = cap_evt[i]
			&& st_reg.capture_control[CCR_STRIDE*i + CCR_INT];
	end

	always_comb begin
		m_reset = 1'b0;
		m_stop = 1'b0;
		for (int i = 0; i < CMT_NMAT; i++) begin
			m_reset |= match_evt[i] && st_reg.match_control[MCR_STRIDE*i + MCR_RST];
			m_stop |= match_evt[i] && st_reg.match_control[MCR_STRIDE*i + MCR_STOP];
		end
	end

	assign restart = st_reg.crst || m_reset;

	// ==========================================================
	// next state; a bus write lands after hardware updates and wins, except over new flags
	always_comb begin
		logic [7:0] a;
		a = reg_addr;
		st_next = st_reg;
		if (st_reg.crst || cap_clear) begin
			st_next.count_value = '0;
			st_next.prescale_count = '0;
		end else if (adv) begin
			if (pre_hit) begin
				st_next.prescale_count = '0;
				// all ones rolls over to zero and raises no flag
				st_next.count_value = m_reset ? 32'h0
					: st_reg.count_value + 32'h1;
			end else begin
				st_next.prescale_count = st_reg.prescale_count + 32'h1;
			end
		end
		if (m_stop) begin
			st_next.cen = 1'b0;
		end
		for (int i = 0; i < CMT_NMAT; i++) begin
			if (restart && st_reg.match_control[MCR_RELOAD_BASE + i]) begin
				st_next.match_registers[i] = st_reg.match_shadow[i];
			end
		end
		for (int i = 0; i < CMT_NCAP; i++) begin
			if (cap_evt[i]) begin
				st_next.capture_value[i] = st_reg.count_value;
			end
		end
		st_next.match_state = mat_next;
		// a new event in the clearing cycle keeps its flag set
		if (reg_wr && a == OFS_IRQ_FLAGS) begin
			st_next.interrupt_flags = st_reg.interrupt_flags
				& ~reg_wdata[IRQ_W-1:0];
		end
		st_next.interrupt_flags = st_next.interrupt_flags | {irq_c, irq_m};
		if (reg_wr) begin
			case (a)
				OFS_COUNT_CTRL: begin
					st_next.cen = reg_wdata[CTL_ENABLE];
					st_next.crst = reg_wdata[CTL_RESET];
				end
				OFS_COUNT_VALUE: st_next.count_value = reg_wdata;
				OFS_PRESCALE_LIMIT: st_next.prescale_limit = reg_wdata;
				OFS_PRESCALE_COUNT: st_next.prescale_count = reg_wdata;
				OFS_MATCH_CTRL: st_next.match_control = reg_wdata[MCR_W-1:0];
				OFS_CAPTURE_CTRL: st_next.capture_control = reg_wdata[CCR_W-1:0];
				OFS_EXT_MATCH_CTRL: begin
					st_next.match_state = reg_wdata[CMT_NMAT-1:0];
					st_next.match_action = reg_wdata[EMR_ACT_BASE +: 2*CMT_NMAT];
				end
				OFS_COUNT_MODE: st_next.count_mode = reg_wdata[MODE_W-1:0];
				OFS_PWM_CTRL: st_next.pwm_control = reg_wdata[CMT_NMAT-1:0];
				default: begin
					for (int i = 0; i < CMT_NMAT; i++) begin
						if (a == OFS_MATCH_REG0 + 8'(i) * OFS_STEP) begin
							st_next.match_registers[i] = reg_wdata;
						end
						if (a == OFS_MATCH_SHADOW0 + 8'(i) * OFS_STEP) begin
							st_next.match_shadow[i] = reg_wdata;
						end
					end
				end
			endcase
		end
		st_next.rdata = '0;
		if (reg_rd) begin
			case (a)
				OFS_IRQ_FLAGS: st_next.rdata = 32'(st_reg.interrupt_flags);
				OFS_COUNT_CTRL: st_next.rdata = 32'({st_reg.crst, st_reg.cen});
				OFS_COUNT_VALUE: st_next.rdata = st_reg.count_value;
				OFS_PRESCALE_LIMIT: st_next.rdata = st_reg.prescale_limit;
				OFS_PRESCALE_COUNT: st_next.rdata = st_reg.prescale_count;
				OFS_MATCH_CTRL: st_next.rdata = 32'(st_reg.match_control);
				OFS_CAPTURE_CTRL: st_next.rdata = 32'(st_reg.capture_control);
				OFS_EXT_MATCH_CTRL: st_next.rdata = 32'({st_reg.match_action,
					st_reg.match_state});
				OFS_COUNT_MODE: st_next.rdata = 32'(st_reg.count_mode);
				OFS_PWM_CTRL: st_next.rdata = 32'(st_reg.pwm_control);
				default: begin
					for (int i = 0; i < CMT_NMAT; i++) begin
						if (a == OFS_MATCH_REG0 + 8'(i) * OFS_STEP) begin
							st_next.rdata = st_reg.match_registers[i];
						end
						if (a == OFS_MATCH_SHADOW0 + 8'(i) * OFS_STEP) begin
							st_next.rdata = st_reg.match_shadow[i];
						end
					end
					for (int i = 0; i < CMT_NCAP; i++) begin
						if (a == OFS_CAPTURE_REG0 + 8'(i) * OFS_STEP) begin
							st_next.rdata = st_reg.capture_value[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign match_output_pin = st_reg.match_state;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_prescale_step;
		adv && !pre_hit && !cap_clear && !reg_wr
		|=> st_reg.prescale_count == $past(st_reg.prescale_count) + 32'h1;
	endproperty
	a_prescale_step: assert property (p_prescale_step)
		else $error("prescaler did not step by one");

	property p_hold_clear;
		st_reg.crst && !reg_wr
		|=> st_reg.count_value == 32'h0 && st_reg.prescale_count == 32'h0;
	endproperty
	a_hold_clear: assert property (p_hold_clear)
		else $error("count not held clear under counter reset");

	property p_wrap;
		tick && !m_reset && !cap_clear && !reg_wr && !(|{irq_c, irq_m})
		&& st_reg.count_value == '1 |=> st_reg.count_value == 32'h0
			&& st_reg.interrupt_flags == $past(st_reg.interrupt_flags);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("count did not wrap quietly");

	property p_stop;
		m_stop && !reg_wr |=> !st_reg.cen ##1 $stable(st_reg.count_value)
			|| $past(reg_wr) || $past(cap_clear);
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop on match failed");

	property p_reset;
		m_reset && !st_reg.crst && !cap_clear && !reg_wr
		|=> st_reg.count_value == 32'h0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset on match failed");

	property p_reload;
		restart && st_reg.match_control[MCR_RELOAD_BASE] && !reg_wr
		|=> st_reg.match_registers[0] == $past(st_reg.match_shadow[0]);
	endproperty
	a_reload: assert property (p_reload)
		else $error("shadow reload of match 0 missing");

	property p_flag_clear;
		reg_wr && reg_addr == OFS_IRQ_FLAGS && reg_wdata[0] && !irq_m[0]
		|=> !st_reg.interrupt_flags[0];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared by writing one");

	property p_match_flag;
		irq_m[1] |=> st_reg.interrupt_flags[1];
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("match flag not raised");

	property p_capture;
		cap_evt[0] |=> st_reg.capture_value[0] == $past(st_reg.count_value)
			&& (!st_reg.capture_control[CCR_INT] || st_reg.interrupt_flags[IRQ_CAP_BASE]);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture 0 did not snapshot the count");

	property p_idle;
		!st_reg.cen && !st_reg.crst && !cap_clear && !reg_wr
		|=> $stable(st_reg.count_value) && $stable(st_reg.prescale_count);
	endproperty
	a_idle: assert property (p_idle)
		else $error("count moved while disabled");

endmodule : cmt_timer

// >>> cmt_pin_model.sv
// far-side model of the capture pins and the match output pins
// assumes the bench asks for pin levels just after a rising clock edge
module cmt_pin_model import cmt_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// requests from the bench
	input wire logic [CMT_NCAP-1:0] lvl_req,
	// pins
	output logic [CMT_NCAP-1:0] capture_input_pin,
	input wire logic [CMT_NMAT-1:0] match_output_pin,
	// observation
	output logic [7:0] m0_changes
);
	timeunit 1ns;
	timeprecision 1ns;

	logic m0_last;

	// ==========================================================
	// capture pins
	// one pin per channel; the bench holds each level at least four clocks
	// so the synchroniser inside always sees it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_input_pin <= 3'h0;
		end else begin
			capture_input_pin <= lvl_req;
		end
	end

	// ==========================================================
	// match pin watch
	// counts every change of match output 0 to see toggles
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			m0_last <= 1'b0;
			m0_changes <= 8'h0;
		end else begin
			m0_last <= match_output_pin[0];
			if (match_output_pin[0] !== m0_last) begin
				m0_changes <= m0_changes + 8'h1;
			end
		end
	end
endmodule : cmt_pin_model

// >>> cmt_timer_tb_top.sv
// self-checking bench for the capture/match timer
// assumes the design of cmt_timer and the pin model beside it
module cmt_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cmt_pkg::*;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [CMT_AW-1:0] reg_addr = 8'h0;
	logic [CMT_DW-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [CMT_DW-1:0] reg_rdata;
	logic [CMT_NCAP-1:0] capture_input_pin;
	logic [CMT_NMAT-1:0] match_output_pin;
	logic [CMT_NCAP-1:0] lvl_req = 3'h0;
	logic [7:0] m0_changes;
	int error_cnt = 0;
	int total_checks = 0;

	always #50 ref_clk = ~ref_clk;

	cmt_timer dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_input_pin(capture_input_pin),
		.match_output_pin(match_output_pin));

	cmt_pin_model pins (.ref_clk(ref_clk), .reset_n(reset_n),
		.lvl_req(lvl_req), .capture_input_pin(capture_input_pin),
		.match_output_pin(match_output_pin), .m0_changes(m0_changes));

	// ==========================================================
	// bus tasks
	// each access leaves one idle cycle after it, so no strobe is
	// raised again in the time step that lowered it
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rc(input string name, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
		chk(name, d, exp);
	endtask : rc

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// watchdog: the tests need well under a thousand cycles
	initial begin
		#(100 * 5000);
		error_cnt++;
		report_and_stop();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rc("ctrl", OFS_COUNT_CTRL, 32'h0);
		rc("match_ctrl", OFS_MATCH_CTRL, 32'h0);
		rc("shadow0", OFS_MATCH_SHADOW0, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		// prescale limit 1 over 7 enabled cycles: 3 ticks, one left over
		wr(OFS_PRESCALE_LIMIT, 32'h1);
		wr(OFS_COUNT_CTRL, 32'h1);
		idle(5);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h3);
		rc("prescale", OFS_PRESCALE_COUNT, 32'h1);
		// counter reset with reload from shadow 0
		wr(OFS_MATCH_SHADOW0, 32'h4);
		wr(OFS_MATCH_CTRL, 32'h0100_0000);
		wr(OFS_COUNT_CTRL, 32'h2);
		rc("count", OFS_COUNT_VALUE, 32'h0);
		rc("prescale", OFS_PRESCALE_COUNT, 32'h0);
		rc("match0", OFS_MATCH_REG0, 32'h4);
		// match 0 at 4 resets count, flags and toggles pin 0; 17 ticks
		wr(OFS_MATCH_CTRL, 32'h0100_0003);
		wr(OFS_EXT_MATCH_CTRL, 32'h30);
		wr(OFS_PRESCALE_LIMIT, 32'h0);
		wr(OFS_COUNT_CTRL, 32'h1);
		idle(15);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h2);
		rc("flags", OFS_IRQ_FLAGS, 32'h1);
		rc("ext_match", OFS_EXT_MATCH_CTRL, 32'h31);
		chk("pin0_changes", {24'h0, m0_changes}, 32'h3);
		chk("pins", {28'h0, match_output_pin}, 32'h1);
		wr(OFS_IRQ_FLAGS, 32'h0);
		rc("flags", OFS_IRQ_FLAGS, 32'h1);
		wr(OFS_IRQ_FLAGS, 32'h1);
		rc("flags", OFS_IRQ_FLAGS, 32'h0);
		// match 1 at 3 stops, flags and drives pin 1 high; the matching
		// increment still lands; match 2 at 0 drives pin 2 low
		wr(OFS_MATCH_REG0 + OFS_STEP, 32'h3);
		wr(OFS_MATCH_CTRL, 32'h0100_002b);
		wr(OFS_EXT_MATCH_CTRL, 32'h1b5);
		wr(OFS_COUNT_CTRL, 32'h2);
		wr(OFS_COUNT_CTRL, 32'h1);
		idle(20);
		rc("ctrl", OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h4);
		rc("flags", OFS_IRQ_FLAGS, 32'h2);
		wr(OFS_IRQ_FLAGS, 32'h2);
		chk("pins", {28'h0, match_output_pin}, 32'h3);
		// wrap from all ones, 3 ticks, no flag
		wr(OFS_MATCH_CTRL, 32'h0);
		wr(OFS_COUNT_VALUE, 32'hffff_ffff);
		wr(OFS_COUNT_CTRL, 32'h1);
		idle(1);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h2);
		rc("flags", OFS_IRQ_FLAGS, 32'h0);
		// capture: ch0 rising with flag, ch1 falling only
		wr(OFS_CAPTURE_CTRL, 32'h15);
		wr(OFS_COUNT_VALUE, 32'h77);
		lvl_req <= 3'h3;
		idle(6);
		wr(OFS_COUNT_VALUE, 32'h55);
		lvl_req <= 3'h0;
		idle(6);
		wr(OFS_CAPTURE_REG0, 32'h1);
		rc("cap0", OFS_CAPTURE_REG0, 32'h77);
		rc("cap1", OFS_CAPTURE_REG0 + OFS_STEP, 32'h55);
		rc("cap2", OFS_CAPTURE_REG0 + 8'h08, 32'h0);
		rc("flags", OFS_IRQ_FLAGS, 32'h10);
		// counter mode: both edges of capture pin 2, then falling only
		wr(OFS_COUNT_VALUE, 32'h0);
		wr(OFS_COUNT_MODE, 32'hb);
		wr(OFS_COUNT_CTRL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			lvl_req <= 3'h4;
			idle(4);
			lvl_req <= 3'h0;
			idle(4);
		end
		wr(OFS_COUNT_MODE, 32'ha);
		lvl_req <= 3'h4;
		idle(4);
		lvl_req <= 3'h0;
		idle(4);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h7);
		// pwm on channel 1: period 5 from match 0, high from count 3 on
		wr(OFS_COUNT_MODE, 32'h0);
		wr(OFS_MATCH_CTRL, 32'h2);
		wr(OFS_PWM_CTRL, 32'h2);
		wr(OFS_COUNT_CTRL, 32'h2);
		wr(OFS_COUNT_CTRL, 32'h1);
		idle(7);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("count", OFS_COUNT_VALUE, 32'h4);
		chk("pins", {28'h0, match_output_pin}, 32'h3);
		wr(OFS_COUNT_CTRL, 32'h2);
		idle(1);
		chk("pins", {28'h0, match_output_pin}, 32'h1);
		// pulse width: rise on pin 0 clears, fall on pin 1 captures
		wr(OFS_MATCH_CTRL, 32'h0);
		wr(OFS_COUNT_MODE, 32'h10);
		wr(OFS_COUNT_CTRL, 32'h1);
		lvl_req <= 3'h3;
		idle(6);
		lvl_req <= 3'h0;
		idle(6);
		wr(OFS_COUNT_CTRL, 32'h0);
		rc("cap1", OFS_CAPTURE_REG0 + OFS_STEP, 32'h5);
		report_and_stop();
	end
endmodule : cmt_timer_tb_top
